// *** common/iss_pkg.sv ***
// Package of constants and types for the internal signal source select block.
`default_nettype none
package iss_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_CLOCK_PIN = 8'h17;
	localparam logic [7:0] IDX_PWM_SRC = 8'h18;
	localparam logic [7:0] IDX_DAC_TRIG = 8'h19;
	localparam logic [7:0] ADDR_CLOCK_PIN = IDX_CLOCK_PIN << 2;
	localparam logic [7:0] ADDR_PWM_SRC = IDX_PWM_SRC << 2;
	localparam logic [7:0] ADDR_DAC_TRIG = IDX_DAC_TRIG << 2;
	localparam int ADDR_W = 8;
	localparam int BUS_W = 32;
	localparam int REG_W = 16;
	localparam logic [15:0] RESET_VALUE = 16'h0000;
	// Writable bits of each register; all other bits are reserved.
	localparam logic [15:0] MASK_CLOCK_PIN = 16'h1000;
	localparam logic [15:0] MASK_PWM_SRC = 16'h29FF;
	localparam logic [15:0] MASK_DAC_TRIG = 16'h0077;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int POS_CRYSTAL_PIN_FUNCTION = 12;
	localparam int POS_SECOND_FAULT_SOURCE = 13;
	localparam int POS_FIRST_FAULT_SOURCE = 11;
	localparam int POS_PAIR_ZERO_SOURCE = 0;
	localparam int POS_PAIR_ONE_SOURCE = 3;
	localparam int POS_PAIR_TWO_SOURCE = 6;
	localparam int POS_DAC_ZERO_TRIGGER = 0;
	localparam int POS_DAC_ONE_TRIGGER = 4;
	localparam int SEL_W = 3;
	// ----------------------------------------------------------------
	// Source codes
	// ----------------------------------------------------------------
	localparam logic [2:0] PSRC_PIN = 3'h0;
	localparam logic [2:0] PSRC_TIMER = 3'h1;
	localparam logic [2:0] PSRC_ADC = 3'h2;
	localparam logic [2:0] PSRC_CMPA = 3'h3;
	localparam logic [2:0] PSRC_CMPB = 3'h4;
	localparam logic [2:0] DSYNC_INTERVAL_TIMER_ZERO = 3'h0;
	localparam logic [2:0] DSYNC_PIT1 = 3'h1;
	localparam logic [2:0] DSYNC_PIT2 = 3'h2;
	localparam logic [2:0] DSYNC_PWM_RELOAD = 3'h3;
	localparam logic [2:0] DSYNC_TIMER0 = 3'h4;
	localparam logic [2:0] DSYNC_TIMER1 = 3'h5;
	// ----------------------------------------------------------------
	// Data widths and synchroniser slots
	// ----------------------------------------------------------------
	localparam int ADC_W = 12;
	localparam int PAIRS = 3;
	localparam int ASYNC_N = 8;
	localparam int SYN_FAULT1 = 0;
	localparam int SYN_FAULT2 = 1;
	localparam int SYN_PSRC0 = 2;
	localparam int SYN_PSRC1 = 3;
	localparam int SYN_CMPA = 4;
	localparam int SYN_CMPB = 5;
	localparam int SYN_XTAL_PIN = 6;
	localparam int SYN_OSC = 7;
	localparam int TIMER_PAIR0 = 0;
	localparam int TIMER_PAIR1 = 2;
	localparam int TIMER_PAIR2 = 3;
	localparam int TIMER_DAC0 = 0;
	localparam int TIMER_DAC1 = 1;
	// ----------------------------------------------------------------
	// State types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] drive;
	} iss_pair_state_type;
	typedef struct packed {
		logic [15:0] clock_pin_function_select;
		logic [15:0] pwm_input_source_select;
		logic [15:0] dac_trigger_source_select;
		logic [ASYNC_N-1:0] sync1;
		logic [ASYNC_N-1:0] sync2;
		logic [ASYNC_N-1:0] sync3;
		logic [ASYNC_N-1:0] stable;
		logic ack;
		logic [31:0] rdata;
		logic fault1;
		logic fault2;
		logic dac_sync0;
		logic dac_sync1;
		logic xtal_out;
		logic xtal_oe;
		logic ext_clk;
	} iss_top_state_type;
endpackage
`default_nettype wire

// *** rtl/iss_pair_source.sv ***
// Source selector for one PWM output pair, with ADC limit comparison.
`timescale 1ns/1ps
`default_nettype none
module iss_pair_source
	import iss_pkg::*;
#(
	parameter bit HAS_PIN = 1'h1
)
(
	input wire logic clk, // System clock.
	input wire logic srst, // Synchronous reset, active high.
	input wire logic [2:0] sel, // Source select code.
	input wire logic pin_src, // Synchronised pin source.
	input wire logic timer_src, // Timer channel output.
	input wire logic cmpa_src, // Synchronised comparator A output.
	input wire logic cmpb_src, // Synchronised comparator B output.
	input wire logic [ADC_W-1:0] adc_result_slot, // ADC result of this slot.
	input wire logic [ADC_W-1:0] adc_high_limit, // High limit of this slot.
	input wire logic [ADC_W-1:0] adc_low_limit, // Low limit of this slot.
	output logic [1:0] drive // Bit 0 even output, bit 1 odd output.
);
	import iss_pkg::*;

	iss_pair_state_type st_reg;
	iss_pair_state_type st_next;

	// ----------------------------------------------------------------
	// Source multiplexer
	// ----------------------------------------------------------------
	// A one-bit source drives the even output true and the odd output inverted.
	// Reserved codes keep the pair where it was, so a stray code cannot glitch it.
	always_comb
	begin
		st_next = st_reg;
		case (sel)
			PSRC_PIN:
			begin
				if (HAS_PIN)
				begin
					st_next.drive = {~pin_src, pin_src};
				end
			end
			PSRC_TIMER: st_next.drive = {~timer_src, timer_src};
			PSRC_ADC:
			begin
				if (adc_result_slot > adc_high_limit)
				begin
					st_next.drive = 2'h2;
				end
				else if (adc_result_slot < adc_low_limit)
				begin
					st_next.drive = 2'h1;
				end
				// Between the limits the pair holds its level.
			end
			PSRC_CMPA: st_next.drive = {~cmpa_src, cmpa_src};
			PSRC_CMPB: st_next.drive = {~cmpb_src, cmpb_src};
			default: st_next = st_reg;
		endcase
	end

	// State register.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	assign drive = st_reg.drive;
endmodule // iss_pair_source
`default_nettype wire

// *** rtl/iss_top.sv ***
// Internal signal source select registers and the multiplexers they steer.
// Function
// - Crystal pin bit 12: 0 drives oscillator out, 1 takes external clock in.
// - Bit 13 feeds second fault from pin, or comparator B when set.
// - Bit 11 feeds first fault from pin, or comparator A when set.
// - Pair two source: timer three, ADC slot two, comparator A or B.
// - Pair two ADC: above high drives even low odd high, below reverses.
// - Pair one source: pin, timer two, ADC slot one, comparator A or B.
// - Pair one ADC: above high drives even low odd high, below reverses.
// - Pair zero source: pin, timer zero, ADC slot zero, comparator A or B.
// - Pair zero ADC: above high drives even low odd high, below reverses.
// - DAC one trigger: interval timers, PWM reload sync, timer channels zero, one.
// - DAC zero trigger uses the same encoding from bits two to zero.
`timescale 1ns/1ps
`default_nettype none
module iss_top
	import iss_pkg::*;
(
	input wire logic REF_CLK, // System clock, 10 MHz.
	input wire logic SRST, // Synchronous reset, active high.
	input wire logic [iss_pkg::ADDR_W-1:0] AVS_ADDRESS, // Byte address.
	input wire logic AVS_READ, // Read request.
	input wire logic AVS_WRITE, // Write request.
	input wire logic [3:0] AVS_BYTEENABLE, // Byte lane enables.
	input wire logic [iss_pkg::BUS_W-1:0] AVS_WRITEDATA, // Write data.
	output logic [iss_pkg::BUS_W-1:0] AVS_READDATA, // Read data.
	output logic AVS_WAITREQUEST, // Stall of the current request.
	input wire logic OSC_OUT, // Crystal oscillator output.
	input wire logic XTAL_PIN_IN, // Crystal pin level in.
	output logic XTAL_PIN_OUT, // Crystal pin level out.
	output logic XTAL_PIN_OE, // Crystal pin drive enable.
	output logic EXT_CLK_IN, // External clock taken from the pin.
	input wire logic FAULT1_PIN, // First fault pin.
	input wire logic FAULT2_PIN, // Second fault pin.
	input wire logic PSRC0_PIN, // Pair zero source pin.
	input wire logic PSRC1_PIN, // Pair one source pin.
	input wire logic CMPA_OUT, // Comparator A output.
	input wire logic CMPB_OUT, // Comparator B output.
	input wire logic [3:0] TIMER_OUT, // Timer channel outputs 0 to 3.
	input wire logic [2:0] PIT_OUT, // Interval timer outputs 0 to 2.
	input wire logic PWM_RELOAD_SYNC, // PWM reload sync.
	input wire logic [iss_pkg::PAIRS-1:0][iss_pkg::ADC_W-1:0] ADC_RESULT, // Slot results.
	input wire logic [iss_pkg::PAIRS-1:0][iss_pkg::ADC_W-1:0] ADC_HIGH, // High limits.
	input wire logic [iss_pkg::PAIRS-1:0][iss_pkg::ADC_W-1:0] ADC_LOW, // Low limits.
	output logic PWM_FAULT1, // First fault input to PWM.
	output logic PWM_FAULT2, // Second fault input to PWM.
	output logic [2*iss_pkg::PAIRS-1:0] PAIR_DRIVE, // Pair sources, even bit first.
	output logic DAC_SYNC0, // DAC zero trigger.
	output logic DAC_SYNC1 // DAC one trigger.
);
	import iss_pkg::*;

	iss_top_state_type st_reg;
	iss_top_state_type st_next;
	logic [ASYNC_N-1:0] async_in;
	logic [PAIRS-1:0][SEL_W-1:0] pair_sel;
	logic [PAIRS-1:0] pair_pin;
	logic [PAIRS-1:0] pair_timer;
	logic request;
	logic [15:0] lane_mask;
	logic fault1_sel;
	logic fault2_sel;
	logic [2:0] dac0_sel;
	logic [2:0] dac1_sel;

	// ----------------------------------------------------------------
	// Input gathering and field views
	// ----------------------------------------------------------------
	// Pins and analog comparator outputs are asynchronous and pass the synchroniser.
	assign async_in[SYN_FAULT1] = FAULT1_PIN;
	assign async_in[SYN_FAULT2] = FAULT2_PIN;
	assign async_in[SYN_PSRC0] = PSRC0_PIN;
	assign async_in[SYN_PSRC1] = PSRC1_PIN;
	assign async_in[SYN_CMPA] = CMPA_OUT;
	assign async_in[SYN_CMPB] = CMPB_OUT;
	assign async_in[SYN_XTAL_PIN] = XTAL_PIN_IN;
	assign async_in[SYN_OSC] = OSC_OUT;

	// Register fields feeding the multiplexers; they act one edge after the write.
	assign fault1_sel = st_reg.pwm_input_source_select[POS_FIRST_FAULT_SOURCE];
	assign fault2_sel = st_reg.pwm_input_source_select[POS_SECOND_FAULT_SOURCE];
	assign pair_sel[0] = st_reg.pwm_input_source_select[POS_PAIR_ZERO_SOURCE +: SEL_W];
	assign pair_sel[1] = st_reg.pwm_input_source_select[POS_PAIR_ONE_SOURCE +: SEL_W];
	assign pair_sel[2] = st_reg.pwm_input_source_select[POS_PAIR_TWO_SOURCE +: SEL_W];
	assign dac0_sel = st_reg.dac_trigger_source_select[POS_DAC_ZERO_TRIGGER +: SEL_W];
	assign dac1_sel = st_reg.dac_trigger_source_select[POS_DAC_ONE_TRIGGER +: SEL_W];

	// Pair two has no pin source, so its pin slot is held low and unused.
	assign pair_pin = {1'h0, st_reg.stable[SYN_PSRC1], st_reg.stable[SYN_PSRC0]};
	assign pair_timer = {TIMER_OUT[TIMER_PAIR2], TIMER_OUT[TIMER_PAIR1], TIMER_OUT[TIMER_PAIR0]};

	// Bus request and byte lanes of the 16-bit registers.
	// Lanes three and two have no register bits behind them and are ignored.
	assign request = AVS_READ | AVS_WRITE;
	assign lane_mask = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	// Each request sees exactly one wait state, which leaves a full cycle to
	// register the read data so the bus never sees a combinational decode path.
	always_comb
	begin
		st_next = st_reg;
		// Three-stage synchroniser; a change counts once stages two and three agree.
		st_next.sync1 = async_in;
		st_next.sync2 = st_reg.sync1;
		st_next.sync3 = st_reg.sync2;
		st_next.stable = (st_reg.sync2 & st_reg.sync3)
			| (st_reg.stable & (st_reg.sync2 ^ st_reg.sync3));
		st_next.ack = request & ~st_reg.ack;
		// Read data are captured in the wait cycle; reserved bits read zero.
		if (request & ~st_reg.ack)
		begin
			if (AVS_ADDRESS == ADDR_CLOCK_PIN)
			begin
				st_next.rdata = {16'h0000, st_reg.clock_pin_function_select};
			end
			else if (AVS_ADDRESS == ADDR_PWM_SRC)
			begin
				st_next.rdata = {16'h0000, st_reg.pwm_input_source_select};
			end
			else if (AVS_ADDRESS == ADDR_DAC_TRIG)
			begin
				st_next.rdata = {16'h0000, st_reg.dac_trigger_source_select};
			end
			else
			begin
				st_next.rdata = 32'h0000_0000;
			end
		end
		// Writes land at the edge where waitrequest is low; unmapped ones are dropped.
		if (AVS_WRITE & st_reg.ack)
		begin
			if (AVS_ADDRESS == ADDR_CLOCK_PIN)
			begin
				st_next.clock_pin_function_select = ((st_reg.clock_pin_function_select
					& ~lane_mask) | (AVS_WRITEDATA[15:0] & lane_mask)) & MASK_CLOCK_PIN;
			end
			else if (AVS_ADDRESS == ADDR_PWM_SRC)
			begin
				st_next.pwm_input_source_select = ((st_reg.pwm_input_source_select
					& ~lane_mask) | (AVS_WRITEDATA[15:0] & lane_mask)) & MASK_PWM_SRC;
			end
			else if (AVS_ADDRESS == ADDR_DAC_TRIG)
			begin
				st_next.dac_trigger_source_select = ((st_reg.dac_trigger_source_select
					& ~lane_mask) | (AVS_WRITEDATA[15:0] & lane_mask)) & MASK_DAC_TRIG;
			end
		end
		// Crystal pin: driven by the oscillator, or released to take a clock in.
		st_next.xtal_oe = ~st_reg.clock_pin_function_select[POS_CRYSTAL_PIN_FUNCTION];
		st_next.xtal_out = st_reg.stable[SYN_OSC] &
			~st_reg.clock_pin_function_select[POS_CRYSTAL_PIN_FUNCTION];
		st_next.ext_clk = st_reg.stable[SYN_XTAL_PIN] &
			st_reg.clock_pin_function_select[POS_CRYSTAL_PIN_FUNCTION];
		// First fault input: pin, or comparator A when its select bit is set.
		if (fault1_sel)
		begin
			st_next.fault1 = st_reg.stable[SYN_CMPA];
		end
		else
		begin
			st_next.fault1 = st_reg.stable[SYN_FAULT1];
		end
		// Second fault input: pin, or comparator B when its select bit is set.
		if (fault2_sel)
		begin
			st_next.fault2 = st_reg.stable[SYN_CMPB];
		end
		else
		begin
			st_next.fault2 = st_reg.stable[SYN_FAULT2];
		end
		// DAC zero trigger; reserved codes give a quiet low trigger.
		case (dac0_sel)
			DSYNC_INTERVAL_TIMER_ZERO:
			begin
				st_next.dac_sync0 = PIT_OUT[0];
			end
			DSYNC_PIT1:
			begin
				st_next.dac_sync0 = PIT_OUT[1];
			end
			DSYNC_PIT2:
			begin
				st_next.dac_sync0 = PIT_OUT[2];
			end
			DSYNC_PWM_RELOAD:
			begin
				st_next.dac_sync0 = PWM_RELOAD_SYNC;
			end
			DSYNC_TIMER0:
			begin
				st_next.dac_sync0 = TIMER_OUT[TIMER_DAC0];
			end
			DSYNC_TIMER1:
			begin
				st_next.dac_sync0 = TIMER_OUT[TIMER_DAC1];
			end
			default:
			begin
				st_next.dac_sync0 = 1'h0;
			end
		endcase
		// DAC one trigger uses the same code table as DAC zero.
		case (dac1_sel)
			DSYNC_INTERVAL_TIMER_ZERO:
			begin
				st_next.dac_sync1 = PIT_OUT[0];
			end
			DSYNC_PIT1:
			begin
				st_next.dac_sync1 = PIT_OUT[1];
			end
			DSYNC_PIT2:
			begin
				st_next.dac_sync1 = PIT_OUT[2];
			end
			DSYNC_PWM_RELOAD:
			begin
				st_next.dac_sync1 = PWM_RELOAD_SYNC;
			end
			DSYNC_TIMER0:
			begin
				st_next.dac_sync1 = TIMER_OUT[TIMER_DAC0];
			end
			DSYNC_TIMER1:
			begin
				st_next.dac_sync1 = TIMER_OUT[TIMER_DAC1];
			end
			default:
			begin
				st_next.dac_sync1 = 1'h0;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	// Every field clears on reset, so each select starts at its default code.
	// The synchronisers clear too, so pins read low for a few cycles after reset.
	always_ff @(posedge REF_CLK)
	begin
		if (SRST)
		begin
			st_reg <= '0;
		end
		else
		begin
			st_reg <= st_next;
		end
	end

	// ----------------------------------------------------------------
	// Pair source selectors
	// ----------------------------------------------------------------
	// Software must keep pin selects consistent; the mux trusts its one pin input.
	genvar gi;
	generate
		for (gi = 0; gi < PAIRS; gi++)
		begin : g_pair
			iss_pair_source #(
				.HAS_PIN(gi != 2)
			) u_pair (
				.clk(REF_CLK),
				.srst(SRST),
				.sel(pair_sel[gi]),
				.pin_src(pair_pin[gi]),
				.timer_src(pair_timer[gi]),
				.cmpa_src(st_reg.stable[SYN_CMPA]),
				.cmpb_src(st_reg.stable[SYN_CMPB]),
				.adc_result_slot(ADC_RESULT[gi]),
				.adc_high_limit(ADC_HIGH[gi]),
				.adc_low_limit(ADC_LOW[gi]),
				.drive(PAIR_DRIVE[2*gi +: 2])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Waitrequest is combinational so a new request stalls in its very first cycle.
	assign AVS_WAITREQUEST = request & ~st_reg.ack;
	// Every other output comes straight from a flip-flop of the state.
	assign AVS_READDATA = st_reg.rdata;
	assign XTAL_PIN_OUT = st_reg.xtal_out;
	assign XTAL_PIN_OE = st_reg.xtal_oe;
	assign EXT_CLK_IN = st_reg.ext_clk;
	assign PWM_FAULT1 = st_reg.fault1;
	assign PWM_FAULT2 = st_reg.fault2;
	assign DAC_SYNC0 = st_reg.dac_sync0;
	assign DAC_SYNC1 = st_reg.dac_sync1;
endmodule // iss_top
`default_nettype wire

// *** testbench/iss_far_end.sv ***
// Model of the timers, comparators, converter and pins around the select block.
`timescale 1ns/1ps
`default_nettype none
module iss_far_end
	import iss_pkg::*;
(
	input wire logic clk, // System clock.
	input wire logic [15:0] pat, // Requested source levels.
	input wire logic [iss_pkg::PAIRS-1:0][iss_pkg::ADC_W-1:0] res, // Requested results.
	output logic [15:0] src = 16'h0000, // Source levels, one driver each.
	output logic [iss_pkg::PAIRS-1:0][iss_pkg::ADC_W-1:0] adc_res = '0 // Slot results.
);
	import iss_pkg::*;

	// Every source moves on a clock edge, as the peripherals do; one pin feeds each input.
	always_ff @(posedge clk)
	begin
		src <= pat;
		adc_res <= res;
	end
endmodule // iss_far_end
`default_nettype wire

// *** testbench/iss_chk.sv ***
// Checker of the bus timing and routing of the select block.
`timescale 1ns/1ps
`default_nettype none
module iss_chk
	import iss_pkg::*;
(
	input wire logic REF_CLK, // Clock.
	input wire logic SRST, // Reset.
	input wire logic [iss_pkg::ADDR_W-1:0] AVS_ADDRESS, // Address.
	input wire logic AVS_READ, // Read.
	input wire logic AVS_WRITE, // Write.
	input wire logic [3:0] AVS_BYTEENABLE, // Lanes.
	input wire logic [iss_pkg::BUS_W-1:0] AVS_WRITEDATA, // Write data.
	input wire logic [iss_pkg::BUS_W-1:0] AVS_READDATA, // Read data.
	input wire logic AVS_WAITREQUEST, // Stall.
	input wire logic XTAL_PIN_OUT, // Pin level out.
	input wire logic XTAL_PIN_OE, // Pin enable.
	input wire logic EXT_CLK_IN, // External clock.
	input wire logic [3:0] TIMER_OUT, // Timers.
	input wire logic [2:0] PIT_OUT, // Interval timers.
	input wire logic [iss_pkg::PAIRS-1:0][iss_pkg::ADC_W-1:0] ADC_RESULT, // Results.
	input wire logic [iss_pkg::PAIRS-1:0][iss_pkg::ADC_W-1:0] ADC_HIGH, // High limits.
	input wire logic [iss_pkg::PAIRS-1:0][iss_pkg::ADC_W-1:0] ADC_LOW, // Low limits.
	input wire logic [2*iss_pkg::PAIRS-1:0] PAIR_DRIVE, // Pair drives.
	input wire logic DAC_SYNC0, // DAC zero trigger.
	input wire logic DAC_SYNC1 // DAC one trigger.
);
	import iss_pkg::*;

	logic [15:0] ck_reg, pw_reg, dc_reg, bm, rsh;
	logic [2:0] rh_reg;
	logic acc, ok, hi2, lo1, mid0;
	// Shadow registers follow accepted writes, so routing is judged without peeking inside.
	assign acc = AVS_WRITE && !AVS_WAITREQUEST;
	assign bm = {{8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
	assign ok = rh_reg == 3'h0;
	assign hi2 = ADC_RESULT[2] > ADC_HIGH[2];
	assign lo1 = ADC_RESULT[1] < ADC_LOW[1] && ADC_RESULT[1] <= ADC_HIGH[1];
	assign mid0 = ADC_RESULT[0] <= ADC_HIGH[0] && ADC_RESULT[0] >= ADC_LOW[0];
	assign rsh = AVS_ADDRESS == ADDR_CLOCK_PIN ? ck_reg : AVS_ADDRESS == ADDR_PWM_SRC ?
		pw_reg : AVS_ADDRESS == ADDR_DAC_TRIG ? dc_reg : 16'h0000;
	function automatic logic [15:0] take(input logic [7:0] a, input logic [15:0] o,
		input logic [15:0] m);
		return (acc && AVS_ADDRESS == a) ? ((o & ~bm) | (AVS_WRITEDATA[15:0] & bm)) & m : o;
	endfunction
	// Reset history keeps the checks quiet while the outputs flush after a reset.
	always_ff @(posedge REF_CLK)
	begin
		rh_reg <= {rh_reg[1:0], SRST};
		ck_reg <= SRST ? 16'h0000 : take(ADDR_CLOCK_PIN, ck_reg, MASK_CLOCK_PIN);
		pw_reg <= SRST ? 16'h0000 : take(ADDR_PWM_SRC, pw_reg, MASK_PWM_SRC);
		dc_reg <= SRST ? 16'h0000 : take(ADDR_DAC_TRIG, dc_reg, MASK_DAC_TRIG);
	end
	default clocking cb @(posedge REF_CLK);
	endclocking
	default disable iff (SRST);
	a_wait_state: assert property (
		$rose(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
		else $error("bus answer not after one wait state");
	a_read_value: assert property (
		AVS_READ && !AVS_WAITREQUEST |-> AVS_READDATA == {16'h0000, rsh})
		else $error("read data differs from written value");
	a_xtal_drive: assert property (ok |-> XTAL_PIN_OE == !$past(ck_reg[12]))
		else $error("crystal pin enable wrong");
	a_xtal_gate: assert property (
		ok |-> ($past(ck_reg[12]) ? !XTAL_PIN_OUT : !EXT_CLK_IN))
		else $error("crystal pin path not gated");
	a_dac_pit: assert property (
		ok && $past(dc_reg[2:0]) == 3'h0 |-> DAC_SYNC0 == $past(PIT_OUT[0]))
		else $error("dac zero trigger not from interval timer zero");
	a_dac_timer: assert property (
		ok && $past(dc_reg[6:4]) == 3'h5 |-> DAC_SYNC1 == $past(TIMER_OUT[1]))
		else $error("dac one trigger not from timer one");
	a_dac_rsvd: assert property (ok && $past(dc_reg[6:5]) == 2'h3 |-> !DAC_SYNC1)
		else $error("reserved dac code gave a trigger");
	a_pair_timer: assert property (
		ok && $past(pw_reg[2:0]) == 3'h1 |-> PAIR_DRIVE[1:0] == {!$past(TIMER_OUT[0]),
		$past(TIMER_OUT[0])}) else $error("pair zero not from timer zero");
	a_pair_high: assert property (
		ok && $past(pw_reg[8:6]) == 3'h2 && $past(hi2) |-> PAIR_DRIVE[5:4] == 2'h2)
		else $error("pair two wrong above high limit");
	a_pair_low: assert property (
		ok && $past(pw_reg[5:3]) == 3'h2 && $past(lo1) |-> PAIR_DRIVE[3:2] == 2'h1)
		else $error("pair one wrong below low limit");
	a_pair_hold: assert property (
		ok && $past(pw_reg[2:0]) == 3'h2 && $past(mid0) |-> $stable(PAIR_DRIVE[1:0]))
		else $error("pair zero moved inside limits");
	c_adc: cover property (ok && $past(pw_reg[8:6]) == 3'h2 && $past(hi2));
	c_dac: cover property (ok && $past(dc_reg[6:4]) == 3'h5);
	c_ext: cover property (ok && $past(ck_reg[12]) && EXT_CLK_IN);
endmodule // iss_chk
bind iss_top iss_chk chk (.REF_CLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
	.AVS_BYTEENABLE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_WAITREQUEST, .XTAL_PIN_OUT,
	.XTAL_PIN_OE, .EXT_CLK_IN, .TIMER_OUT, .PIT_OUT, .ADC_RESULT, .ADC_HIGH, .ADC_LOW,
	.PAIR_DRIVE, .DAC_SYNC0, .DAC_SYNC1);
`default_nettype wire

// *** testbench/iss_top_test.sv ***
// Self-checking bench for the select registers and their multiplexers.
`timescale 1ns/1ps
`default_nettype none
module iss_top_test
	import iss_pkg::*;
;
	import iss_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus tables and signals
	// ----------------------------------------------------------------
	localparam logic [3:0][15:0] MASKS = {16'h0000, MASK_DAC_TRIG, MASK_PWM_SRC, MASK_CLOCK_PIN};
	localparam int DBIT [8] = '{10, 11, 12, 13, 6, 7, 10, 10};
	localparam int PBIT [3][5] = '{'{2, 6, 0, 4, 5}, '{3, 8, 0, 4, 5}, '{0, 9, 0, 4, 5}};
	localparam logic [11:0] ARES [4] = '{12'h384, 12'h320, 12'h064, 12'h0C8};
	localparam logic [7:0] AEXP [4] = '{8'h2A, 8'h2A, 8'h15, 8'h15};
	logic clk = 1'h0, srst = 1'h1, rd = 1'h0, wr = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000, rdata;
	logic [15:0] pat = 16'h0000, src;
	logic [PAIRS-1:0][ADC_W-1:0] res_q = '0, adc_res;
	logic [PAIRS-1:0][ADC_W-1:0] hi_q = {3{12'h320}}, lo_q = {3{12'h0C8}};
	logic wait_req, xo, xoe, ext, f1, f2, d0, d1;
	logic [5:0] drv;
	int error_cnt = 0;
	int tests_run = 0;
	// Free-running system clock, 100 ns period.
	always #50 clk = ~clk;
	iss_far_end far (.clk(clk), .pat(pat), .res(res_q), .src(src), .adc_res(adc_res));
	iss_top uut (.REF_CLK(clk), .SRST(srst), .AVS_ADDRESS(addr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_BYTEENABLE(4'hF), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata),
		.AVS_WAITREQUEST(wait_req), .OSC_OUT(src[14]), .XTAL_PIN_IN(xoe ? xo : src[15]),
		.XTAL_PIN_OUT(xo), .XTAL_PIN_OE(xoe), .EXT_CLK_IN(ext), .FAULT1_PIN(src[0]),
		.FAULT2_PIN(src[1]), .PSRC0_PIN(src[2]), .PSRC1_PIN(src[3]), .CMPA_OUT(src[4]),
		.CMPB_OUT(src[5]), .TIMER_OUT(src[9:6]), .PIT_OUT(src[12:10]),
		.PWM_RELOAD_SYNC(src[13]), .ADC_RESULT(adc_res), .ADC_HIGH(hi_q), .ADC_LOW(lo_q),
		.PWM_FAULT1(f1), .PWM_FAULT2(f2), .PAIR_DRIVE(drv), .DAC_SYNC0(d0), .DAC_SYNC1(d1));
	// ----------------------------------------------------------------
	// Bus, compare and closing tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		chk_reg({24'h000000, got}, {24'h000000, exp});
	endtask
	// Request is held until waitrequest is seen low at an edge; only then released.
	task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		rd <= r;
		wr <= !r;
		addr <= a;
		wdata <= d;
		// No cycle count is assumed; a stalled slave is left to the watchdog.
		do
		begin
			@(posedge clk);
		end
		while (wait_req !== 1'h0);
		q = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [15:0] d);
		logic [31:0] q;
		bus(1'h0, a, {16'h0000, d}, q);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'h1, a, 32'h00000000, q);
		chk_reg(q, exp);
	endtask
	// Sources change only while the selects stand still; synchronisers need a few edges.
	task automatic set_src(input logic [15:0] p);
		@(posedge clk);
		pat <= p;
		repeat (8) @(posedge clk);
	endtask
	function automatic logic [15:0] pick(input int b, input logic v);
		return v ? 16'h0001 << b : ~(16'h0001 << b);
	endfunction
	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial
	begin
		logic [31:0] q;
		logic [15:0] m;
		repeat (5) @(posedge clk);
		srst <= 1'h0;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 4; i++)
		begin
			rchk(ADDR_CLOCK_PIN + 8'(4 * i), 32'h00000000);
			bus(1'h0, ADDR_CLOCK_PIN + 8'(4 * i), 32'hFFFFFFFF, q);
			rchk(ADDR_CLOCK_PIN + 8'(4 * i), {16'h0000, MASKS[i]});
			wreg(ADDR_CLOCK_PIN + 8'(4 * i), 16'h0000);
		end
		for (int p = 0; p < 3; p++)
			for (int c = 0; c < 5; c++)
				for (int k = 0; k < 2; k++)
					if (c != 2 && !(p == 2 && c == 0))
					begin
						wreg(ADDR_PWM_SRC, 16'(c << (3 * p)));
						set_src(pick(PBIT[p][c], k[0]));
						chk_pin({6'h00, drv[2 * p +: 2]}, {6'h00, !k[0], k[0]});
					end
		wreg(ADDR_PWM_SRC, 16'h0000);
		set_src(16'h0000);
		chk_pin({2'h0, drv}, 8'h1A);
		wreg(ADDR_PWM_SRC, 16'h0007);
		set_src(16'hFFFF);
		chk_pin({2'h0, drv}, 8'h16);
		wreg(ADDR_PWM_SRC, 16'h0092);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			res_q <= {3{ARES[i]}};
			set_src(16'h0000);
			chk_pin({2'h0, drv}, AEXP[i]);
		end
		for (int s = 0; s < 2; s++)
		begin
			wreg(ADDR_PWM_SRC, s ? 16'h2800 : 16'h0000);
			m = s ? 16'h0030 : 16'h0003;
			for (int k = 0; k < 2; k++)
			begin
				set_src(k ? m : ~m);
				chk_pin({6'h00, f2, f1}, {6'h00, k[0], k[0]});
			end
		end
		for (int s = 0; s < 2; s++)
		begin
			wreg(ADDR_CLOCK_PIN, s ? 16'h1000 : 16'h0000);
			m = s ? 16'h8000 : 16'h4000;
			for (int k = 0; k < 2; k++)
			begin
				set_src(k ? m : ~m);
				chk_pin({5'h00, xoe, xo, ext}, s ? {7'h00, k[0]} : {5'h01, k[0], 1'h0});
			end
		end
		for (int c = 0; c < 8; c++)
		begin
			wreg(ADDR_DAC_TRIG, 16'((c << 4) | c));
			for (int k = 0; k < 2; k++)
			begin
				set_src(pick(DBIT[c], k[0]));
				chk_pin({6'h00, d1, d0}, (c < 6) ? {6'h00, k[0], k[0]} : 8'h00);
			end
		end
		test_done;
	end
	// Watchdog well beyond the several hundred cycles the sequence needs.
	initial
	begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		test_done;
	end
endmodule // iss_top_test
`default_nettype wire
